/* File: hw/ppi_host.sv */
// Host controller driving a polled parallel port with three peripherals
// Assumes a Wishbone classic master and the port device on the I/O pins
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
// How it works
// - Host writes configuration word 83 hex first
// - Busy masks 04, 02, 01 hex
// - Bit set/reset words toggle single strobes
// - Init sets every active-low strobe inactive
// - Printer strobe lasts at least 0.5 us
// - Never strobe printer while busy
// - Print: poll idle, write byte, strobe
// - Punch command strobe punches high tracks
// - Punch ready level serves as busy
// - Drive-right strobe reads one reader character
// - Read: strobe, poll, read, release strobe
// - Ports at f4 to f7, A1:A0 select
// - Unused select address bits held at one; only A1:A0 (io_a) are driven here
module ppi_host
  import ppi_host_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] io_d_in,
  output logic [1:0] io_a,
  output logic io_cs_n,
  output logic io_rd_n,
  output logic io_wr_n,
  output logic [7:0] io_d_out,
  output logic io_d_oe
);
  seq_state_e state_r, state_nxt;
  logic [7:0] data_r;
  logic [7:0] rxd_r;
  logic [2:0] cmd_r;
  logic done_r, err_r, init_r;
  logic [7:0] wait_r;
  logic io_start;
  logic io_wr;
  logic [7:0] io_addr;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic io_done;
  wire busy = (state_r != st_idle);

  // Wishbone decode
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_ctrl = wb_req && wb_we_i && (wb_adr_i == reg_ctrl) && wb_sel_i[0];
  wire wr_data = wb_req && wb_we_i && (wb_adr_i == reg_data) && wb_sel_i[0];
  wire clr_stat = wb_req && wb_we_i && (wb_adr_i == reg_stat) && wb_sel_i[0];
  wire [2:0] new_cmd = wb_dat_i[2:0];
  wire cmd_ok = (new_cmd == cmd_init) || (init_r && ((new_cmd == cmd_print)
    || (new_cmd == cmd_punch) || (new_cmd == cmd_read)));
  wire launch = wr_ctrl && !busy;
  wire refuse = wr_ctrl && (busy || !cmd_ok);
  wire [31:0] rd_word;
  assign rd_word = (wb_adr_i == reg_ctrl) ? {29'h0, cmd_r} :
    (wb_adr_i == reg_data) ? {24'h0, data_r} :
    (wb_adr_i == reg_stat) ? {28'h0, init_r, err_r, done_r, busy} :
    (wb_adr_i == reg_rxd) ? {24'h0, rxd_r} : 32'h0;

  // Busy bit for the selected device, nonzero means busy
  function automatic logic dev_busy(input logic [2:0] c, input logic [7:0] st);
    logic [7:0] m;
    m = (c == cmd_print) ? busy_mask_prn :
      (c == cmd_punch) ? busy_mask_pun : busy_mask_rdr;
    dev_busy = |(st & m);
  endfunction

  // printer and punch strobes, on bits six and five
  function automatic logic [7:0] strobe_word(input logic [2:0] c, input logic on);
    logic [7:0] w;
    w = (c == cmd_print) ? bsr_prn_set : bsr_pun_set;
    strobe_word = on ? {w[7:1], 1'b0} : w;
  endfunction

  // I/O cycle request for each state
  always_comb
  begin
    io_start = 1'b0;
    io_wr = 1'b1;
    io_addr = addr_configuration_word;
    io_wdata = 8'h00;
    case (state_r)
      st_cfg:
      begin
        io_start = 1'b1;
        io_wdata = cfg_word_value;
      end
      st_init_prn:
      begin
        io_start = 1'b1;
        io_wdata = bsr_prn_set;
      end
      st_init_pun:
      begin
        io_start = 1'b1;
        io_wdata = bsr_pun_set;
      end
      st_init_rdr:
      begin
        io_start = 1'b1;
        io_wdata = bsr_rdr_set;
      end
      st_poll, st_rd_poll:
      begin
        io_start = 1'b1;
        io_wr = 1'b0;
        io_addr = addr_status_strobe_port;
      end
      st_data:
      begin
        io_start = 1'b1;
        io_addr = addr_output_data_port;
        io_wdata = data_r;
      end
      st_stb_on:
      begin
        io_start = 1'b1;
        io_wdata = strobe_word(cmd_r, 1'b1);
      end
      st_stb_off:
      begin
        io_start = 1'b1;
        io_wdata = strobe_word(cmd_r, 1'b0);
      end
      st_rd_on:
      begin
        io_start = 1'b1;
        io_wdata = bsr_rdr_clr;
      end
      st_rd_get:
      begin
        io_start = 1'b1;
        io_wr = 1'b0;
        io_addr = addr_input_data_port;
      end
      st_rd_off:
      begin
        io_start = 1'b1;
        io_wdata = bsr_rdr_set;
      end
      default:
      begin
        io_start = 1'b0;
      end
    endcase
  end

  // Sequencer
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      st_idle:
        if (launch && cmd_ok)
        begin
          if (new_cmd == cmd_init)
            state_nxt = st_cfg;
          else if (new_cmd == cmd_read)
            state_nxt = st_rd_on;
          else
            state_nxt = st_poll;
        end
      st_cfg:
        if (io_done)
          state_nxt = st_init_prn;
      st_init_prn:
        if (io_done)
          state_nxt = st_init_pun;
      st_init_pun:
        if (io_done)
          state_nxt = st_init_rdr;
      st_init_rdr:
        if (io_done)
          state_nxt = st_idle;
      st_poll:
        if (io_done && !dev_busy(cmd_r, io_rdata))
          state_nxt = st_data;
      st_data:
        if (io_done)
          state_nxt = st_stb_on;
      st_stb_on:
        if (io_done)
          state_nxt = st_stb_wait;
      st_stb_wait:
        if (wait_r == 8'h00)
          state_nxt = st_stb_off;
      st_stb_off:
        if (io_done)
          state_nxt = st_idle;
      st_rd_on:
        if (io_done)
          state_nxt = st_rd_poll;
      st_rd_poll:
        if (io_done && !dev_busy(cmd_read, io_rdata))
          state_nxt = st_rd_get;
      st_rd_get:
        if (io_done)
          state_nxt = st_rd_off;
      st_rd_off:
        if (io_done)
          state_nxt = st_idle;
      default:
        state_nxt = st_idle;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      state_r <= st_idle;
      wait_r <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == st_stb_on && io_done)
        wait_r <= 8'(strobe_cycles - 1);
      else if (wait_r != 8'h00)
        wait_r <= wait_r - 8'h01;
    end
  end

  // Software-visible registers; completion set wins over clear
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      cmd_r <= 3'h0;
      data_r <= 8'h00;
      rxd_r <= 8'h00;
      done_r <= 1'b0;
      err_r <= 1'b0;
      init_r <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_word : 32'h0;
      if (launch && cmd_ok)
        cmd_r <= new_cmd;
      if (wr_data && !busy)
        data_r <= wb_dat_i[7:0];
      if (state_r == st_rd_get && io_done)
        rxd_r <= io_rdata;
      if (state_r == st_init_rdr && io_done)
        init_r <= 1'b1;
      if (busy && state_nxt == st_idle)
        done_r <= 1'b1;
      else if (clr_stat && wb_dat_i[stat_done_bit])
        done_r <= 1'b0;
      if (refuse)
        err_r <= 1'b1;
      else if (clr_stat && wb_dat_i[stat_err_bit])
        err_r <= 1'b0;
    end
  end

  // upper select bits are not driven; only io_a reaches the device
  io_cycle u_io
  (
    .core_clk(core_clk),
    .nrst(nrst),
    .start(io_start && !io_done),
    .wr(io_wr),
    .addr(io_addr),
    .wdata(io_wdata),
    .io_d_in(io_d_in),
    .io_a(io_a),
    .io_cs_n(io_cs_n),
    .io_rd_n(io_rd_n),
    .io_wr_n(io_wr_n),
    .io_d_out(io_d_out),
    .io_d_oe(io_d_oe),
    .rdata(io_rdata),
    .done(io_done)
  );

  a_strobe_len: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(state_r == st_stb_wait) |-> (state_r == st_stb_wait) [*8]
    ##1 (state_r == st_stb_wait) [*8] ##1 (state_r == st_stb_wait) [*3])
    else $error("strobe held too short");
  a_poll_gate: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_r == st_poll && io_done && dev_busy(cmd_r, io_rdata)) |=> state_r == st_poll)
    else $error("data sent while busy");
  a_init_order: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_r == st_cfg && io_done) |=> state_r == st_init_prn)
    else $error("config not followed by strobe init");
  a_rd_release: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_r == st_rd_get && io_done) |=> state_r == st_rd_off ##[1:12] state_r == st_idle)
    else $error("reader strobe not released");
  a_ack_once: assert property (@(posedge core_clk) disable iff (!nrst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_io_addr: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_r == st_rd_get && $fell(io_cs_n)) |-> io_a == addr_input_data_port[1:0] && io_wr_n)
    else $error("wrong port for reader data");
  a_cfg_word: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_r == st_cfg && !io_cs_n) |-> io_a == addr_configuration_word[1:0]
    && io_d_out == cfg_word_value && io_d_oe)
    else $error("configuration word wrong");
  a_data_port: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_r == st_data && !io_cs_n) |-> io_a == addr_output_data_port[1:0]
    && io_d_out == data_r && io_d_oe)
    else $error("output byte not on output port");
  a_busy_read: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_r == st_poll && !io_cs_n) |-> io_a == addr_status_strobe_port[1:0]
    && !io_rd_n && !io_d_oe)
    else $error("busy levels not read from status port");
  a_strobe_on: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_r == st_stb_on && !io_cs_n) |-> io_a == addr_configuration_word[1:0]
    && io_d_out == ((cmd_r == cmd_print) ? bsr_prn_clr : bsr_pun_clr))
    else $error("wrong strobe assert word");
  a_strobe_off: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_r == st_stb_off && !io_cs_n) |-> io_a == addr_configuration_word[1:0]
    && io_d_out == ((cmd_r == cmd_print) ? bsr_prn_set : bsr_pun_set))
    else $error("wrong strobe release word");
  a_rd_wait: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_r == st_rd_poll && io_done && |(io_rdata & busy_mask_rdr))
    |=> state_r == st_rd_poll)
    else $error("reader data taken while busy");
endmodule // ppi_host

/* File: include/ppi_host_pkg.sv */
// Constants for the polled parallel port host controller
// Assumes one 40 MHz clock and a port device reached over a plain I/O bus
package ppi_host_pkg;
  // Device I/O addresses
  localparam logic [7:0] addr_output_data_port = 8'hf4;
  localparam logic [7:0] addr_input_data_port = 8'hf5;
  localparam logic [7:0] addr_status_strobe_port = 8'hf6;
  localparam logic [7:0] addr_configuration_word = 8'hf7;
  // Configuration value and bit set/reset words
  localparam logic [7:0] cfg_word_value = 8'h83;
  localparam logic [7:0] bsr_prn_set = 8'h0d;
  localparam logic [7:0] bsr_prn_clr = 8'h0c;
  localparam logic [7:0] bsr_pun_set = 8'h0b;
  localparam logic [7:0] bsr_pun_clr = 8'h0a;
  localparam logic [7:0] bsr_rdr_set = 8'h09;
  localparam logic [7:0] bsr_rdr_clr = 8'h08;
  // Busy masks on the status/strobe port
  localparam logic [7:0] busy_mask_prn = 8'h04;
  localparam logic [7:0] busy_mask_pun = 8'h02;
  localparam logic [7:0] busy_mask_rdr = 8'h01;
  // Controller's own Wishbone registers (byte addresses)
  localparam logic [3:0] reg_ctrl = 4'h0;
  localparam logic [3:0] reg_data = 4'h4;
  localparam logic [3:0] reg_stat = 4'h8;
  localparam logic [3:0] reg_rxd = 4'hc;
  // Command codes in ctrl[2:0]
  localparam logic [2:0] cmd_init = 3'h1;
  localparam logic [2:0] cmd_print = 3'h2;
  localparam logic [2:0] cmd_punch = 3'h3;
  localparam logic [2:0] cmd_read = 3'h4;
  // Status bit positions
  localparam int stat_busy_bit = 0;
  localparam int stat_done_bit = 1;
  localparam int stat_err_bit = 2;
  localparam int stat_init_bit = 3;
  // Timing
  localparam int clk_mhz = 40;
  localparam int strobe_min_ns = 500;
  localparam int strobe_cycles = (strobe_min_ns * clk_mhz + 999) / 1000;
  localparam int io_cycles = 4;
  typedef enum logic [3:0] {
    st_idle = 4'b0000,
    st_cfg = 4'b0001,
    st_init_prn = 4'b0010,
    st_init_pun = 4'b0011,
    st_init_rdr = 4'b0100,
    st_poll = 4'b0101,
    st_data = 4'b0110,
    st_stb_on = 4'b0111,
    st_stb_wait = 4'b1000,
    st_stb_off = 4'b1001,
    st_rd_on = 4'b1010,
    st_rd_poll = 4'b1011,
    st_rd_get = 4'b1100,
    st_rd_off = 4'b1101
  } seq_state_e;
endpackage

/* File: hw/io_cycle.sv */
// Single I/O bus cycle generator toward the port device
// Assumes the device samples writes and drives read data in a fixed window
`timescale 1ns/1ps
module io_cycle
  import ppi_host_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] io_d_in,
  output logic [1:0] io_a,
  output logic io_cs_n,
  output logic io_rd_n,
  output logic io_wr_n,
  output logic [7:0] io_d_out,
  output logic io_d_oe,
  output logic [7:0] rdata,
  output logic done
);
  logic [2:0] cnt_r;
  logic active_r;
  logic wr_r;
  wire last = active_r && (cnt_r == 3'(io_cycles - 1));

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      active_r <= 1'b0;
      cnt_r <= 3'h0;
      wr_r <= 1'b0;
      io_a <= 2'h0;
      io_cs_n <= 1'b1;
      io_rd_n <= 1'b1;
      io_wr_n <= 1'b1;
      io_d_out <= 8'h00;
      io_d_oe <= 1'b0;
      rdata <= 8'h00;
      done <= 1'b0;
    end
    else
    begin
      done <= last;
      if (start && !active_r)
      begin
        active_r <= 1'b1;
        cnt_r <= 3'h0;
        wr_r <= wr;
        // Two low address bits pick the port
        io_a <= addr[1:0];
        io_cs_n <= 1'b0;
        io_rd_n <= wr;
        io_wr_n <= !wr;
        io_d_out <= wdata;
        io_d_oe <= wr;
      end
      else if (last)
      begin
        active_r <= 1'b0;
        io_cs_n <= 1'b1;
        io_rd_n <= 1'b1;
        io_wr_n <= 1'b1;
        io_d_oe <= 1'b0;
        if (!wr_r)
          rdata <= io_d_in;
      end
      else if (active_r)
        cnt_r <= cnt_r + 3'h1;
    end
  end
endmodule // io_cycle

/* File: verification/port_device_model.sv */
// Model of the polled port device, its busy lines and its strobes
// Assumes each host I/O cycle holds cs_n low with address and data stable
`timescale 1ns/1ps
module port_device_model
(
  input wire logic core_clk,
  input wire logic [1:0] io_a,
  input wire logic io_cs_n,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  input wire logic [7:0] io_d_out,
  input wire logic io_d_oe,
  output logic [7:0] io_d_in,
  input wire logic [2:0] busy_in,
  input wire logic [7:0] rdr_data,
  output logic [7:0] out_port,
  output logic [2:0] strobe,
  output logic [7:0] cfg
);
  logic [7:0] last_d;
  logic [7:0] rd_val;
  logic cfg_wr;
  logic bsr_wr;
  initial
  begin
    last_d = 8'h00;
    out_port = 8'h00;
    strobe = 3'h0;
    cfg = 8'h00;
  end
  assign rd_val = io_a == 2'h0 ? out_port : io_a == 2'h1 ? rdr_data :
                  io_a == 2'h2 ? {1'b0, strobe, 1'b0, busy_in} : ~last_d;
  // Undriven bus keeps changing
  assign io_d_in = io_d_oe ? io_d_out : (!io_cs_n && !io_rd_n) ? rd_val : ~last_d;
  assign cfg_wr = !io_cs_n && !io_wr_n && io_a == 2'h3 && io_d_out[7];
  // bit set/reset only on bits 4 to 6
  assign bsr_wr = !io_cs_n && !io_wr_n && io_a == 2'h3 && !io_d_out[7] &&
                  io_d_out[3:1] >= 3'h4 && io_d_out[3:1] <= 3'h6;
  always @(posedge core_clk)
  begin
    last_d <= io_d_in;
    if (!io_cs_n && !io_wr_n && io_a == 2'h0)
      out_port <= io_d_out;
    if (!io_cs_n && !io_wr_n && io_a == 2'h2)
      strobe <= io_d_out[6:4];
    if (cfg_wr)
      cfg <= io_d_out;
    if (cfg_wr)
      strobe <= 3'h0;
    if (bsr_wr)
      strobe[2'(io_d_out[3:1] - 3'h4)] <= io_d_out[0];
  end
endmodule // port_device_model

/* File: verification/status_polled_parallel_port_bench.sv */
// Self-checking bench for the polled port host controller
// Assumes the device model on the I/O pins and a Wishbone master here
`timescale 1ns/1ps
module status_polled_parallel_port_bench;
  import ppi_host_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h1;
  logic [31:0] dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0] io_d_in, io_d_out, out_port, cfg;
  logic [1:0] io_a;
  logic io_cs_n, io_rd_n, io_wr_n, io_d_oe;
  logic [2:0] busy_in = 3'h0;
  logic [2:0] strobe, prev;
  logic [7:0] rdr_data = 8'h00;
  logic [31:0] r;
  int fail_count = 0;
  int compares = 0;
  int falls[3] = '{0, 0, 0};
  int low_n = 0;
  int low_last = 0;

  ppi_host i_ppi_host (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .io_d_in(io_d_in), .io_a(io_a), .io_cs_n(io_cs_n),
    .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .io_d_out(io_d_out), .io_d_oe(io_d_oe));
  port_device_model i_port_device_model (.core_clk(core_clk), .io_a(io_a),
    .io_cs_n(io_cs_n), .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .io_d_out(io_d_out),
    .io_d_oe(io_d_oe), .io_d_in(io_d_in), .busy_in(busy_in), .rdr_data(rdr_data),
    .out_port(out_port), .strobe(strobe), .cfg(cfg));

  initial
  begin
    forever #12.5 core_clk = ~core_clk;
  end

  // Strobe fall counts and printer strobe low time
  always @(posedge core_clk)
  begin
    prev <= strobe;
    for (int k = 0; k < 3; k++)
      falls[k] <= falls[k] + ((prev[k] === 1'b1 && strobe[k] === 1'b0) ? 1 : 0);
    low_n <= strobe[2] ? 0 : low_n + 1;
    if (strobe[2] === 1'b1 && prev[2] === 1'b0)
      low_last <= low_n;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    if (fail_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1)
      @(posedge core_clk);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, a, d, x);
  endtask

  task rd(input logic [3:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask

  task wait_idle;
    logic [31:0] s;
    s = 32'h1;
    while (s[stat_busy_bit] !== 1'b0)
      rd(reg_stat, s);
  endtask

  initial
  begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    wrap_up;
  end

  initial
  begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    // A print command before setup is refused
    wr(reg_data, 32'h5a);
    wr(reg_ctrl, 32'(cmd_print));
    rd(reg_stat, r);
    check(r[stat_err_bit], 1'b1);
    wr(reg_stat, 32'h6);
    busy_in <= 3'b111;
    wr(reg_ctrl, 32'(cmd_init));
    wait_idle;
    check(cfg, cfg_word_value);
    check(strobe, 3'b111);
    rd(reg_stat, r);
    check(r[stat_init_bit], 1'b1);
    // Undefined command code is refused
    wr(reg_ctrl, 32'h7);
    rd(reg_stat, r);
    check(r[3:0], 4'he);
    wr(reg_stat, 32'h6);
    // Printer held busy: no strobe until it drops
    wr(reg_data, 32'hc3);
    wr(reg_ctrl, 32'(cmd_print));
    repeat (200) @(posedge core_clk);
    check(falls[2], 0);
    // Data and command writes refused while busy
    wr(reg_data, 32'h11);
    wr(reg_ctrl, 32'(cmd_read));
    rd(reg_stat, r);
    check(r[3:0], 4'hd);
    wr(reg_stat, 32'h4);
    busy_in <= 3'b011;
    wait_idle;
    check(out_port, 8'hc3);
    check(falls[2], 1);
    check(low_last >= 20, 1);
    rd(reg_stat, r);
    check(r[stat_done_bit], 1'b1);
    rd(reg_data, r);
    check(r, 32'hc3);
    rd(reg_ctrl, r);
    check(r, 32'(cmd_print));
    wr(reg_stat, 32'h2);
    // Punch busy, printer idle
    wr(reg_data, 32'h3c);
    wr(reg_ctrl, 32'(cmd_punch));
    repeat (200) @(posedge core_clk);
    check(falls[1], 0);
    busy_in <= 3'b101;
    wait_idle;
    check(out_port, 8'h3c);
    check(falls[1], 1);
    check(falls[2], 1);
    check(strobe, 3'b111);
    // Reader with printer still busy
    rdr_data <= 8'ha5;
    wr(reg_ctrl, 32'(cmd_read));
    repeat (100) @(posedge core_clk);
    check(strobe, 3'b110);
    busy_in <= 3'b100;
    wait_idle;
    rd(reg_rxd, r);
    check(r[7:0], 8'ha5);
    check(strobe, 3'b111);
    check(falls[0], 1);
    rd(4'h6, r);
    check(r, 32'h0);
    wrap_up;
  end
endmodule // status_polled_parallel_port_bench
